// ===== csx_pkg.sv
// Package of the cyclic status word exchange: word layouts, default placement and map.
// Assumes it is compiled before every other file of the block.
package csx_pkg;
    localparam int         WORD_W          = 16;
    localparam int         AREA_WORDS      = 32;
    localparam int         IDX_W           = 5;
    localparam int         ADDR_W          = 16;
    localparam int         UNIT_W          = 4;
    localparam logic [15:0] OUT_BASE_DEF   = 16'h05dc;
    localparam logic [15:0] IN_BASE_DEF    = 16'h05eb;
    localparam logic [15:0] UNIT_STRIDE    = 16'h0019;
    localparam logic [4:0] OUT_STATUS_WORDS = 5'h01;
    localparam logic [4:0] IN_STATUS_WORDS  = 5'h02;
    localparam int         SW_FIELD_MSB    = 14;
    localparam int         SYS_BIT         = 15;
    localparam int         ERR_MEM_OVF     = 0;
    localparam int         ERR_COMP_LO     = 1;
    localparam int         ERR_COMP_HI     = 2;
    localparam int         ERR_ECODE       = 3;
    localparam int         ERR_BATT        = 15;
    localparam logic [15:0] COMP_CODE_LIMIT = 16'h00ff;
    localparam logic [15:0] WORD_RESET     = 16'h0000;
    localparam logic [7:0] WB_CTRL         = 8'h00;
    localparam logic [7:0] WB_OUT_BASE     = 8'h04;
    localparam logic [7:0] WB_IN_BASE      = 8'h08;
    localparam logic [7:0] WB_SWITCH       = 8'h0c;
    localparam logic [7:0] WB_HOST_STATUS  = 8'h10;
    localparam logic [7:0] WB_TASKS        = 8'h14;
    localparam logic [7:0] WB_ERRORS       = 8'h18;
    localparam logic [7:0] WB_IRQ_STATUS   = 8'h1c;
    localparam logic [7:0] WB_IRQ_CLEAR    = 8'h20;
    localparam logic [7:0] WB_IRQ_ENABLE   = 8'h24;
    localparam logic [7:0] WB_PASS         = 8'h28;
    localparam logic [7:0] WB_AREA         = 8'h80;
    localparam int         IRQ_W           = 2;
    localparam int         IRQ_PASS_DONE   = 0;
    localparam int         IRQ_ERR_RISE    = 1;
    typedef enum logic [1:0] {
        CSX_IDLE  = 2'b00,
        CSX_OUT   = 2'b01,
        CSX_IN    = 2'b11,
        CSX_DONE  = 2'b10
    } csx_pass_t;
endpackage

// ===== csx_link_if.sv
// Interface joining the host CPU end and the module end of the cyclic exchange.
// Assumes both ends run on one common clock.
`timescale 1ns/1ps
interface csx_link_if;
    logic                       pass_start;
    logic [csx_pkg::ADDR_W-1:0] out_base;
    logic [csx_pkg::ADDR_W-1:0] in_base;
    logic                       out_valid;
    logic [csx_pkg::IDX_W-1:0]  out_index;
    logic [csx_pkg::WORD_W-1:0] out_word;
    logic                       in_req;
    logic [csx_pkg::IDX_W-1:0]  in_index;
    logic [csx_pkg::WORD_W-1:0] in_word;
    logic                       in_valid;
    logic                       pass_done;
    modport host   (output pass_start, out_valid, out_index, out_word, in_req, in_index,
                    input out_base, in_base, in_word, in_valid, pass_done);
    modport module_end (input pass_start, out_valid, out_index, out_word, in_req, in_index,
                        output out_base, in_base, in_word, in_valid, pass_done);
endinterface

// ===== csx_area_mem.sv
// Word-addressed store of one cyclic area, one write and one registered read port.
// Assumes a single clock and that writes and reads come from the owning end.
`timescale 1ns/1ps
module csx_area_mem (
    input  wire logic                       CLK_IN,
    input  wire logic                       we_in,
    input  wire logic [csx_pkg::IDX_W-1:0]  waddr_in,
    input  wire logic [csx_pkg::WORD_W-1:0] wdata_in,
    input  wire logic [csx_pkg::IDX_W-1:0]  raddr_in,
    output logic      [csx_pkg::WORD_W-1:0] rdata_out
);
    logic [csx_pkg::WORD_W-1:0] mem_q [csx_pkg::AREA_WORDS];

    always_ff @(posedge CLK_IN) begin
        if (we_in) begin
            mem_q[waddr_in] <= wdata_in;
        end
    end

    // Read port is registered; contents are user data and carry no reset.
    always_ff @(posedge CLK_IN) begin
        rdata_out <= mem_q[raddr_in];
    end
endmodule // csx_area_mem

// ===== csx_module_end.sv
// Module end: keeps the input status words, passes user words, places default areas.
// Assumes the host end drives the link on CLK_IN and paces every pass.
//
// Behaviour
// - Transfer index selects base plus index word.
// - Status words never hold user data.
// - Host copies switch word into bits 0-14.
// - Output status bit 15 carries no meaning.
// - Default output area at 1500 plus 25*unit.
// - Default input area at 1515 plus 25*unit.
// - Sixteen task flags follow running tasks.
// - Bit 0 set on code/variable overflow.
// - Bit 1 set on compile error <=255.
// - Bit 2 set on compile error >=256.
// - Bit 3 set on bad intermediate code.
// - Host ignores error bits 4 to 14.
// - Battery bit clears after recovery, edit, run.
// - User words pass through uninterpreted.
// - Transfers follow each host service pass.
// - Trace-off command clears overflow and compile flags.
//
// Our own choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
module csx_module_end (
    input  wire logic                         CLK_IN,
    input  wire logic                         RESET_N_IN,
    csx_link_if.module_end                    link,
    input  wire logic [csx_pkg::UNIT_W-1:0]   UNIT_NUMBER_IN,
    input  wire logic                         CFG_OVERRIDE_IN,
    input  wire logic [csx_pkg::ADDR_W-1:0]   CFG_OUT_BASE_IN,
    input  wire logic [csx_pkg::ADDR_W-1:0]   CFG_IN_BASE_IN,
    input  wire logic [csx_pkg::WORD_W-1:0]   TASK_RUNNING_IN,
    input  wire logic                         MEM_OVERFLOW_IN,
    input  wire logic                         COMPILE_ERROR_IN,
    input  wire logic [csx_pkg::WORD_W-1:0]   COMPILE_CODE_IN,
    input  wire logic                         ECODE_ERROR_IN,
    input  wire logic                         BATTERY_LOW_IN,
    input  wire logic                         PROGRAM_EDITED_IN,
    input  wire logic                         PROGRAM_RUN_IN,
    input  wire logic                         TRACE_OFF_COMMAND_IN,
    input  wire logic                         USER_WE_IN,
    input  wire logic [csx_pkg::IDX_W-1:0]    USER_INDEX_IN,
    input  wire logic [csx_pkg::WORD_W-1:0]   USER_WDATA_IN,
    output logic      [csx_pkg::WORD_W-1:0]   USER_RDATA_OUT,
    output logic      [csx_pkg::WORD_W-1:0]   HOST_STATUS_OUT,
    output logic      [csx_pkg::WORD_W-1:0]   TASK_FLAGS_OUT,
    output logic      [csx_pkg::WORD_W-1:0]   ERROR_FLAGS_OUT,
    output logic                              PASS_SEEN_OUT
);
    logic [csx_pkg::WORD_W-1:0] host_status_q;
    logic [csx_pkg::WORD_W-1:0] task_q;
    logic [csx_pkg::WORD_W-1:0] err_q;
    logic [csx_pkg::ADDR_W-1:0] out_base_q;
    logic [csx_pkg::ADDR_W-1:0] in_base_q;
    logic [csx_pkg::ADDR_W-1:0] unit_off;
    logic                       batt_ok_q;
    logic                       edited_q;
    logic                       in_req_q;
    logic [csx_pkg::IDX_W-1:0]  in_idx_q;
    logic                       pass_seen_q;
    logic                       out_user_we;
    logic                       in_user_we;
    logic [csx_pkg::WORD_W-1:0] out_rdata;
    logic [csx_pkg::WORD_W-1:0] in_rdata;

    assign unit_off = 16'(UNIT_NUMBER_IN) * csx_pkg::UNIT_STRIDE;

    // Bases are held in registers so the host sees a stable map through a pass.
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            out_base_q <= csx_pkg::WORD_RESET;
            in_base_q  <= csx_pkg::WORD_RESET;
        end else if (CFG_OVERRIDE_IN) begin
            out_base_q <= CFG_OUT_BASE_IN;
            in_base_q  <= CFG_IN_BASE_IN;
        end else begin
            out_base_q <= csx_pkg::OUT_BASE_DEF + unit_off;
            in_base_q  <= csx_pkg::IN_BASE_DEF + unit_off;
        end
    end
    assign link.out_base = out_base_q;
    assign link.in_base  = in_base_q;

    // Output area: index 0 is the host status word, the rest goes to user storage.
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            host_status_q <= csx_pkg::WORD_RESET;
        end else if (link.out_valid && link.out_index == 5'h00) begin
            host_status_q <= {1'b0, link.out_word[csx_pkg::SW_FIELD_MSB:0]};
        end
    end
    assign out_user_we = link.out_valid && (link.out_index >= csx_pkg::OUT_STATUS_WORDS);

    csx_area_mem u_out_area (
        .CLK_IN    (CLK_IN),
        .we_in     (out_user_we),
        .waddr_in  (link.out_index),
        .wdata_in  (link.out_word),
        .raddr_in  (USER_INDEX_IN),
        .rdata_out (out_rdata)
    );

    // Module program writes user words of the input area; status slots are refused.
    assign in_user_we = USER_WE_IN && (USER_INDEX_IN > csx_pkg::IN_STATUS_WORDS - 5'h01);

    csx_area_mem u_in_area (
        .CLK_IN    (CLK_IN),
        .we_in     (in_user_we),
        .waddr_in  (USER_INDEX_IN),
        .wdata_in  (USER_WDATA_IN),
        .raddr_in  (link.in_index),
        .rdata_out (in_rdata)
    );

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            USER_RDATA_OUT <= csx_pkg::WORD_RESET;
        end else begin
            USER_RDATA_OUT <= out_rdata;
        end
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            task_q <= csx_pkg::WORD_RESET;
        end else begin
            task_q <= TASK_RUNNING_IN;
        end
    end

    // Battery flag needs recovery, then an edit, then a run, in that order.
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            batt_ok_q <= 1'b0;
            edited_q  <= 1'b0;
        end else if (BATTERY_LOW_IN) begin
            batt_ok_q <= 1'b0;
            edited_q  <= 1'b0;
        end else begin
            batt_ok_q <= 1'b1;
            if (batt_ok_q && PROGRAM_EDITED_IN) begin
                edited_q <= 1'b1;
            end else if (PROGRAM_RUN_IN && edited_q) begin
                edited_q <= 1'b0;
            end
        end
    end

    // Set wins over the trace-off clear when both land in one cycle.
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            err_q <= csx_pkg::WORD_RESET;
        end else begin
            if (MEM_OVERFLOW_IN) begin
                err_q[csx_pkg::ERR_MEM_OVF] <= 1'b1;
            end else if (TRACE_OFF_COMMAND_IN) begin
                err_q[csx_pkg::ERR_MEM_OVF] <= 1'b0;
            end
            if (COMPILE_ERROR_IN && COMPILE_CODE_IN <= csx_pkg::COMP_CODE_LIMIT) begin
                err_q[csx_pkg::ERR_COMP_LO] <= 1'b1;
            end else if (TRACE_OFF_COMMAND_IN) begin
                err_q[csx_pkg::ERR_COMP_LO] <= 1'b0;
            end
            if (COMPILE_ERROR_IN && COMPILE_CODE_IN > csx_pkg::COMP_CODE_LIMIT) begin
                err_q[csx_pkg::ERR_COMP_HI] <= 1'b1;
            end else if (TRACE_OFF_COMMAND_IN) begin
                err_q[csx_pkg::ERR_COMP_HI] <= 1'b0;
            end
            if (ECODE_ERROR_IN) begin
                err_q[csx_pkg::ERR_ECODE] <= 1'b1;
            end
            if (BATTERY_LOW_IN) begin
                err_q[csx_pkg::ERR_BATT] <= 1'b1;
            end else if (edited_q && PROGRAM_RUN_IN) begin
                err_q[csx_pkg::ERR_BATT] <= 1'b0;
            end
            err_q[14:4] <= 11'h000;
        end
    end

    // Input area read: index 0 and 1 are status, others come from user storage.
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            in_req_q <= 1'b0;
            in_idx_q <= 5'h00;
        end else begin
            in_req_q <= link.in_req;
            in_idx_q <= link.in_index;
        end
    end

    always_comb begin
        unique case (in_idx_q)
            5'h00:   link.in_word = task_q;
            5'h01:   link.in_word = err_q;
            default: link.in_word = in_rdata;
        endcase
    end
    assign link.in_valid  = in_req_q;
    assign link.pass_done = 1'b0;

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            pass_seen_q <= 1'b0;
        end else begin
            pass_seen_q <= link.pass_start;
        end
    end

    assign HOST_STATUS_OUT = host_status_q;
    assign TASK_FLAGS_OUT  = task_q;
    assign ERROR_FLAGS_OUT = err_q;
    assign PASS_SEEN_OUT   = pass_seen_q;
endmodule // csx_module_end

// ===== csx_host_end.sv
// Host CPU end: Wishbone registers, a local word image, and the cyclic pass engine.
// Assumes the module end answers an input read one cycle after the request.
`timescale 1ns/1ps
module csx_host_end (
    input  wire logic        CLK_IN,
    input  wire logic        RESET_N_IN,
    csx_link_if.host         link,
    input  wire logic        WB_CYC_IN,
    input  wire logic        WB_STB_IN,
    input  wire logic        WB_WE_IN,
    input  wire logic [7:0]  WB_ADR_IN,
    input  wire logic [3:0]  WB_SEL_IN,
    input  wire logic [31:0] WB_DAT_IN,
    output logic      [31:0] WB_DAT_OUT,
    output logic             WB_ACK_OUT,
    output logic             IRQ_OUT
);
    logic [csx_pkg::WORD_W-1:0] out_img_q [csx_pkg::AREA_WORDS];
    logic [csx_pkg::WORD_W-1:0] in_img_q  [csx_pkg::AREA_WORDS];
    logic [csx_pkg::WORD_W-1:0] switch_q;
    logic [csx_pkg::IDX_W-1:0]  len_q;
    logic                       go_q;
    logic [15:0]                pass_cnt_q;
    csx_pkg::csx_pass_t         st_q;
    logic [csx_pkg::IDX_W-1:0]  idx_q;
    logic [csx_pkg::IRQ_W-1:0]  irq_st_q;
    logic [csx_pkg::IRQ_W-1:0]  irq_en_q;
    logic                       ack_q;
    logic                       wb_req;
    logic                       wb_wr;
    logic                       area_sel;
    logic [csx_pkg::IDX_W-1:0]  area_idx;
    logic                       done_ev;
    logic                       err_ev;
    logic [csx_pkg::WORD_W-1:0] err_prev_q;

    assign wb_req   = WB_CYC_IN && WB_STB_IN && !ack_q;
    // Writes land on the edge that samples ack, which is where a classic master commits them.
    assign wb_wr    = WB_CYC_IN && WB_STB_IN && ack_q && WB_WE_IN && WB_SEL_IN[0];
    assign area_sel = WB_ADR_IN[7];
    assign area_idx = WB_ADR_IN[6:2];

    // Software writes user words of the output image; index 0 is built from the switch word.
    always_ff @(posedge CLK_IN) begin
        if (wb_wr && area_sel && area_idx != 5'h00) begin
            out_img_q[area_idx] <= WB_DAT_IN[15:0];
        end
        out_img_q[0] <= {1'b0, switch_q[csx_pkg::SW_FIELD_MSB:0]};
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            switch_q <= csx_pkg::WORD_RESET;
            len_q    <= 5'h1f;
            irq_en_q <= 2'h0;
        end else if (wb_wr && !area_sel) begin
            unique case (WB_ADR_IN)
                csx_pkg::WB_SWITCH:     switch_q <= WB_DAT_IN[15:0];
                csx_pkg::WB_CTRL:       len_q    <= WB_DAT_IN[5:1];
                csx_pkg::WB_IRQ_ENABLE: irq_en_q <= WB_DAT_IN[1:0];
                default:                ;
            endcase
        end
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            go_q <= 1'b0;
        end else begin
            go_q <= wb_wr && !area_sel && WB_ADR_IN == csx_pkg::WB_CTRL && WB_DAT_IN[0];
        end
    end

    // One service pass: send output words 0..len, then fetch input words 0..len.
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            st_q  <= csx_pkg::CSX_IDLE;
            idx_q <= 5'h00;
        end else begin
            unique case (st_q)
                csx_pkg::CSX_IDLE: if (go_q) begin
                    st_q  <= csx_pkg::CSX_OUT;
                    idx_q <= 5'h00;
                end
                csx_pkg::CSX_OUT: begin
                    idx_q <= idx_q + 5'h01;
                    if (idx_q == len_q) begin
                        st_q  <= csx_pkg::CSX_IN;
                        idx_q <= 5'h00;
                    end
                end
                csx_pkg::CSX_IN: begin
                    idx_q <= idx_q + 5'h01;
                    if (idx_q == len_q) begin
                        st_q <= csx_pkg::CSX_DONE;
                    end
                end
                csx_pkg::CSX_DONE: st_q <= csx_pkg::CSX_IDLE;
            endcase
        end
    end

    assign link.pass_start = go_q && st_q == csx_pkg::CSX_IDLE;
    assign link.out_valid  = st_q == csx_pkg::CSX_OUT;
    assign link.out_index  = idx_q;
    assign link.out_word   = out_img_q[idx_q];
    assign link.in_req     = st_q == csx_pkg::CSX_IN;
    assign link.in_index   = idx_q;
    assign done_ev         = st_q == csx_pkg::CSX_DONE;

    // Input answers come one cycle after the request, so the index lags by one.
    logic [csx_pkg::IDX_W-1:0] in_idx_d1_q;
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            in_idx_d1_q <= 5'h00;
        end else begin
            in_idx_d1_q <= idx_q;
        end
    end
    always_ff @(posedge CLK_IN) begin
        if (link.in_valid) begin
            in_img_q[in_idx_d1_q] <= link.in_word;
        end
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            pass_cnt_q <= 16'h0000;
            err_prev_q <= csx_pkg::WORD_RESET;
        end else begin
            if (done_ev) begin
                pass_cnt_q <= pass_cnt_q + 16'h0001;
                err_prev_q <= in_img_q[1] & 16'h800f;
            end
        end
    end
    assign err_ev = done_ev && ((in_img_q[1] & 16'h800f & ~err_prev_q) != 16'h0000);

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            irq_st_q <= 2'h0;
        end else begin
            for (int i = 0; i < csx_pkg::IRQ_W; i++) begin
                if ((i == csx_pkg::IRQ_PASS_DONE && done_ev) ||
                    (i == csx_pkg::IRQ_ERR_RISE && err_ev)) begin
                    irq_st_q[i] <= 1'b1;
                end else if (wb_wr && !area_sel && WB_ADR_IN == csx_pkg::WB_IRQ_CLEAR &&
                             WB_DAT_IN[i]) begin
                    irq_st_q[i] <= 1'b0;
                end
            end
        end
    end
    assign IRQ_OUT = |(irq_st_q & irq_en_q);

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            ack_q      <= 1'b0;
            WB_DAT_OUT <= 32'h00000000;
        end else begin
            ack_q      <= wb_req;
            WB_DAT_OUT <= 32'h00000000;
            if (wb_req && !WB_WE_IN) begin
                if (area_sel) begin
                    WB_DAT_OUT <= {16'h0000, in_img_q[area_idx]};
                end else begin
                    unique case (WB_ADR_IN)
                        csx_pkg::WB_CTRL:        WB_DAT_OUT <= {26'h0, len_q, 1'b0};
                        csx_pkg::WB_OUT_BASE:    WB_DAT_OUT <= {16'h0000, link.out_base};
                        csx_pkg::WB_IN_BASE:     WB_DAT_OUT <= {16'h0000, link.in_base};
                        csx_pkg::WB_SWITCH:      WB_DAT_OUT <= {16'h0000, switch_q};
                        csx_pkg::WB_TASKS:       WB_DAT_OUT <= {16'h0000, in_img_q[0]};
                        csx_pkg::WB_ERRORS:      WB_DAT_OUT <= {16'h0000, in_img_q[1] & 16'h800f};
                        csx_pkg::WB_IRQ_STATUS:  WB_DAT_OUT <= {30'h0, irq_st_q};
                        csx_pkg::WB_IRQ_ENABLE:  WB_DAT_OUT <= {30'h0, irq_en_q};
                        csx_pkg::WB_PASS:        WB_DAT_OUT <= {16'h0000, pass_cnt_q};
                        default:                 WB_DAT_OUT <= 32'h00000000;
                    endcase
                end
            end
        end
    end
    assign WB_ACK_OUT = ack_q;
endmodule // csx_host_end

// ===== csx_chk.sv
// Checker of the link between the two ends of the cyclic status word exchange.
// Assumes one clock, an active-low reset and passes that cover all 32 words.
`timescale 1ns/1ps
module csx_chk #(parameter int UNIT = 0) (
    input wire logic        CLK_IN,
    input wire logic        RESET_N_IN,
    input wire logic        pass_start,
    input wire logic [15:0] out_base,
    input wire logic [15:0] in_base,
    input wire logic        out_valid,
    input wire logic [4:0]  out_index,
    input wire logic        in_req,
    input wire logic [4:0]  in_index,
    input wire logic [15:0] in_word,
    input wire logic        in_valid
);
    localparam logic [15:0] OUTB = 16'(csx_pkg::OUT_BASE_DEF + csx_pkg::UNIT_STRIDE * UNIT);
    localparam logic [15:0] INB  = 16'(csx_pkg::IN_BASE_DEF + csx_pkg::UNIT_STRIDE * UNIT);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RESET_N_IN);
    out_base_a: assert property (pass_start |-> out_base == OUTB)
        else $error("Output area base is off.");
    in_base_a: assert property (pass_start |-> in_base == INB)
        else $error("Input area base is off.");
    pass_begin_a: assert property (pass_start |-> ##[0:2] (out_valid && out_index == 5'h00))
        else $error("Pass did not begin at word zero.");
    out_step_a: assert property (out_valid && out_index != 5'h1f |=> out_valid && out_index == $past(out_index) + 5'h01)
        else $error("Output index did not step by one.");
    out_to_in_a: assert property (out_valid && out_index == 5'h1f |-> ##[1:2] (in_req && in_index == 5'h00))
        else $error("Input phase did not follow.");
    in_step_a: assert property (in_req && in_index != 5'h1f |=> in_req && in_index == $past(in_index) + 5'h01)
        else $error("Input index did not step by one.");
    in_answer_a: assert property (in_req |=> in_valid)
        else $error("Input word not answered.");
    no_overlap_a: assert property (!(out_valid && in_req))
        else $error("Both directions active at once.");
    reserved_zero_a: assert property (in_req && in_index == 5'h01 |=> in_word[14:4] == 11'h000)
        else $error("Undefined error bits not zero.");
endmodule // csx_chk

// ===== test_cyclic_status_word_exchange.sv
// Testbench joining the host end and the module end, driven over Wishbone and events.
// Assumes a bus answer within 50 cycles; the plain default placement, unit 3.
`timescale 1ns/1ps
module test_cyclic_status_word_exchange;
    localparam int UNIT = 3;
    logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq;
    logic        bat = 1'b0, edit = 1'b0, run = 1'b0, trc = 1'b0, uwe = 1'b0;
    logic [3:0]  sel = 4'h0, ev = 4'h0;
    logic [4:0]  uidx = 5'h00;
    logic [7:0]  adr = 8'h00;
    logic [15:0] tasks = 16'h0000, uwd = 16'h0000, e = 16'h0000, urd, hst, tfl, efl;
    logic [31:0] wdat = 32'h0, rdat, q;
    int          failures = 0, n_tests = 0;
    csx_link_if  link ();
    csx_module_end u_csx_module_end (
        .CLK_IN(clk), .RESET_N_IN(rst_n), .link(link), .UNIT_NUMBER_IN(4'(UNIT)),
        .CFG_OVERRIDE_IN(1'b0), .CFG_OUT_BASE_IN(16'h0000), .CFG_IN_BASE_IN(16'h0000),
        .TASK_RUNNING_IN(tasks), .MEM_OVERFLOW_IN(ev[0]), .COMPILE_ERROR_IN(ev[1] | ev[2]),
        .COMPILE_CODE_IN(ev[2] ? 16'h0100 : 16'h00ff), .ECODE_ERROR_IN(ev[3]),
        .BATTERY_LOW_IN(bat), .PROGRAM_EDITED_IN(edit), .PROGRAM_RUN_IN(run),
        .TRACE_OFF_COMMAND_IN(trc), .USER_WE_IN(uwe), .USER_INDEX_IN(uidx),
        .USER_WDATA_IN(uwd), .USER_RDATA_OUT(urd), .HOST_STATUS_OUT(hst),
        .TASK_FLAGS_OUT(tfl), .ERROR_FLAGS_OUT(efl), .PASS_SEEN_OUT());
    csx_host_end u_csx_host_end (
        .CLK_IN(clk), .RESET_N_IN(rst_n), .link(link), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
        .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
        .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .IRQ_OUT(irq));
    csx_chk #(.UNIT(UNIT)) u_csx_chk (
        .CLK_IN(clk), .RESET_N_IN(rst_n), .pass_start(link.pass_start),
        .out_base(link.out_base), .in_base(link.in_base), .out_valid(link.out_valid),
        .out_index(link.out_index), .in_req(link.in_req), .in_index(link.in_index),
        .in_word(link.in_word), .in_valid(link.in_valid));
    always #2.5 clk = ~clk;
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // The request is held until ack is seen at a rising edge, so no cycle is assumed.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        for (int i = 0; i < 50 && ack !== 1'b1; i++) @(posedge clk);
        if (ack !== 1'b1) begin
            failures++;
            end_sim();
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic run_pass();
        wb(1'b1, 8'h20, 32'h3);
        wb(1'b1, 8'h00, 32'h3f);
        q = 32'h0;
        for (int i = 0; i < 100 && q[0] !== 1'b1; i++) wb(1'b0, 8'h1c, 32'h0);
        if (q[0] !== 1'b1) begin
            failures++;
            end_sim();
        end
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        wb(1'b1, 8'h40, 32'h1);
        wb(1'b0, 8'h40, 32'h0);
        chk(q, 32'h0);
        wb(1'b0, 8'h04, 32'h0);
        chk(q, 32'h0627);
        wb(1'b0, 8'h08, 32'h0);
        chk(q, 32'h0636);
        $display("test bases done");
        wb(1'b1, 8'h0c, 32'hffff);
        wb(1'b1, 8'h80, 32'h0);
        wb(1'b1, 8'h94, 32'ha5a5);
        tasks <= 16'h8001;
        uwe <= 1'b1;
        uidx <= 5'h02;
        uwd <= 16'h5a5a;
        @(posedge clk);
        uidx <= 5'h01;
        uwd <= 16'hdead;
        @(posedge clk);
        uwe <= 1'b0;
        uidx <= 5'h05;
        for (int i = 0; i < 4; i++) begin
            ev <= 4'h1 << i;
            @(posedge clk);
            ev <= 4'h0;
            repeat (2) @(posedge clk);
            e = e | (16'h0001 << i);
            chk({16'h0000, efl}, {16'h0000, e});
        end
        bat <= 1'b1;
        repeat (2) @(posedge clk);
        chk({16'h0000, efl}, 32'h800f);
        $display("test events done");
        wb(1'b1, 8'h24, 32'h1);
        run_pass();
        chk(q, 32'h3);
        chk({31'h0, irq}, 32'h1);
        chk({16'h0000, hst}, 32'h7fff);
        chk({16'h0000, urd}, 32'ha5a5);
        wb(1'b0, 8'h80, 32'h0);
        chk(q, 32'h8001);
        wb(1'b0, 8'h84, 32'h0);
        chk(q, 32'h800f);
        wb(1'b0, 8'h88, 32'h0);
        chk(q, 32'h5a5a);
        wb(1'b0, 8'h18, 32'h0);
        chk(q, 32'h800f);
        wb(1'b1, 8'h20, 32'h1);
        chk({31'h0, irq}, 32'h0);
        $display("test first pass done");
        trc <= 1'b1;
        @(posedge clk);
        trc <= 1'b0;
        repeat (2) @(posedge clk);
        chk({16'h0000, efl}, 32'h8008);
        bat <= 1'b0;
        repeat (2) @(posedge clk);
        run <= 1'b1;
        @(posedge clk);
        run <= 1'b0;
        repeat (2) @(posedge clk);
        chk({16'h0000, efl}, 32'h8008);
        edit <= 1'b1;
        @(posedge clk);
        edit <= 1'b0;
        run <= 1'b1;
        @(posedge clk);
        run <= 1'b0;
        tasks <= 16'h0000;
        repeat (2) @(posedge clk);
        chk({16'h0000, efl}, 32'h0008);
        chk({16'h0000, tfl}, 32'h0);
        wb(1'b1, 8'h24, 32'h0);
        run_pass();
        chk(q, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wb(1'b0, 8'h28, 32'h0);
        chk(q, 32'h2);
        wb(1'b0, 8'h84, 32'h0);
        chk(q, 32'h0008);
        $display("test second pass done");
        end_sim();
    end
endmodule // test_cyclic_status_word_exchange
